// File: pptc_bank.sv
// Port priority and tag control register bank with AXI4-Lite access
`timescale 1ns/1ps
`default_nettype none

module pptc_bank (
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [pptc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [pptc_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [pptc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [pptc_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Ingress classification inputs, one bit per port
	input wire logic [pptc_pkg::PORTS-1:0] ing_valid,
	input wire logic [pptc_pkg::PORTS-1:0] ing_dscp_hit,
	input wire logic [pptc_pkg::PORTS-1:0] ing_dscp_high,
	input wire logic [pptc_pkg::PORTS-1:0] ing_dot1p_hit,
	input wire logic [pptc_pkg::PORTS-1:0] ing_dot1p_high,
	// Egress packet descriptors, one per port
	input wire logic [pptc_pkg::PORTS-1:0] eg_valid,
	input wire logic [pptc_pkg::PORTS-1:0] eg_rx_tagged,
	input wire logic [pptc_pkg::PORTS-1:0][pptc_pkg::PIDX_W-1:0] eg_src_port,
	input wire logic [pptc_pkg::PORTS-1:0] eg_prio_high,
	// Ingress results
	output logic [pptc_pkg::PORTS-1:0] ing_storm_en,
	output logic [pptc_pkg::PORTS-1:0] ing_prio_valid,
	output logic [pptc_pkg::PORTS-1:0] ing_prio_high,
	// Egress results
	output logic [pptc_pkg::PORTS-1:0] eg_out_valid,
	output logic [pptc_pkg::PORTS-1:0] eg_add_tag,
	output logic [pptc_pkg::PORTS-1:0] eg_strip_tag,
	output logic [pptc_pkg::PORTS-1:0][pptc_pkg::PIDX_W-1:0] eg_vid_port,
	output logic [pptc_pkg::PORTS-1:0] eg_queue_high
);
	import pptc_pkg::*;

	// ----------------------------------------------------------------
	// Storage and decode
	// ----------------------------------------------------------------
	logic [7:0] ctrl [PORTS];
	logic [ADDR_W-1:0] wr_addr;
	logic [7:0] wr_data;
	logic wr_strb0;
	logic [2:0] wr_idx;
	logic [2:0] rd_idx;
	logic do_write;

	// Maps a byte address to a port index, or none
	function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
		logic [2:0] idx;
		idx = IDX_NONE;
		unique case (a)
			PORT1_CTRL_OFS: idx = 3'h0;
			PORT2_CTRL_OFS: idx = 3'h1;
			PORT3_CTRL_OFS: idx = 3'h2;
			PORT4_CTRL_OFS: idx = 3'h3;
			PORT5_CTRL_OFS: idx = 3'h4;
			default: idx = IDX_NONE;
		endcase
		return idx;
	endfunction : reg_index

	// Both halves held and no response pending
	assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wr_idx = reg_index(wr_addr);
	assign rd_idx = reg_index(s_axi_araddr);

	// ----------------------------------------------------------------
	// Write channels
	// ----------------------------------------------------------------

	// Address and data are taken in either order, then held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
			end
		end
	end

	// Payload capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_addr <= '0;
			wr_data <= 8'h00;
			wr_strb0 <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				wr_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wr_data <= s_axi_wdata[7:0];
				wr_strb0 <= s_axi_wstrb[0];
			end
		end
	end

	// Response; unmapped addresses answer with an error and change nothing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wr_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Port control registers
	// ----------------------------------------------------------------

	// Only byte lane 0 carries a register; upper lanes are dropped.
	// Bit 3 is kept for software but steers nothing.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < PORTS; i++) begin
				ctrl[i] <= CTRL_RST;
			end
		end else if (do_write && wr_strb0 && wr_idx != IDX_NONE) begin
			ctrl[wr_idx] <= wr_data;
		end
	end

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------

	// One read at a time; data answered on the edge after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			if (rd_idx == IDX_NONE) begin
				s_axi_rdata <= '0;
				s_axi_rresp <= RESP_SLVERR;
			end else begin
				s_axi_rdata <= {24'h000000, ctrl[rd_idx]};
				s_axi_rresp <= RESP_OKAY;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Per-port decision logic
	// ----------------------------------------------------------------

	// Same logic for every port, fed from its own control byte
	for (genvar p = 0; p < PORTS; p++) begin : g_port
		pptc_port_if pif ();

		assign pif.ctrl = ctrl[p];
		assign pif.ing_valid = ing_valid[p];
		assign pif.dscp_hit = ing_dscp_hit[p];
		assign pif.dscp_high = ing_dscp_high[p];
		assign pif.dot1p_hit = ing_dot1p_hit[p];
		assign pif.dot1p_high = ing_dot1p_high[p];
		assign pif.eg_valid = eg_valid[p];
		assign pif.eg_rx_tagged = eg_rx_tagged[p];
		assign pif.eg_src_port = eg_src_port[p];
		assign pif.eg_prio_high = eg_prio_high[p];

		pptc_port_logic u_port (
			.aclk(aclk),
			.aresetn(aresetn),
			.pif(pif.core)
		);

		// Results leave straight from the port flops
		assign ing_storm_en[p] = pif.storm_en;
		assign ing_prio_valid[p] = pif.ing_prio_valid;
		assign ing_prio_high[p] = pif.ing_prio_high;
		assign eg_out_valid[p] = pif.eg_out_valid;
		assign eg_add_tag[p] = pif.add_tag;
		assign eg_strip_tag[p] = pif.strip_tag;
		assign eg_vid_port[p] = pif.vid_port;
		assign eg_queue_high[p] = pif.queue_high;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	reg_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(do_write && wr_strb0 && wr_idx != IDX_NONE)
		|=> ctrl[$past(wr_idx)] == $past(wr_data))
		else $error("register write not stored");
	write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
		else $error("write response missing");
	read_back_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready && rd_idx != IDX_NONE)
		|=> s_axi_rvalid && s_axi_rresp == RESP_OKAY && s_axi_rdata[31:8] == 24'h000000)
		else $error("read answer wrong");
	reset_clear_a: assert property (@(posedge aclk)
		!aresetn |=> ctrl[0] == CTRL_RST && ctrl[1] == CTRL_RST && ctrl[2] == CTRL_RST
			&& ctrl[3] == CTRL_RST && ctrl[4] == CTRL_RST)
		else $error("control not cleared by reset");

	// ----------------------------------------------------------------
	// Bus and reset checks
	// ----------------------------------------------------------------

	// Bus idle after reset, so the first request is taken at once
	reset_bus_a: assert property (@(posedge aclk)
		!aresetn |=> s_axi_awready && s_axi_wready && s_axi_arready
			&& !s_axi_bvalid && !s_axi_rvalid)
		else $error("bus not idle after reset");
	reset_out_a: assert property (@(posedge aclk)
		!aresetn |=> ing_storm_en == '0 && ing_prio_valid == '0 && ing_prio_high == '0
			&& eg_out_valid == '0 && eg_add_tag == '0 && eg_strip_tag == '0
			&& eg_queue_high == '0)
		else $error("switch outputs not cleared by reset");

	// Read answers: the addressed byte, or zero and an error elsewhere
	read_data_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready && rd_idx != IDX_NONE)
		|=> s_axi_rdata[7:0] == $past(ctrl[rd_idx]))
		else $error("read data not from addressed register");
	read_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready && rd_idx == IDX_NONE)
		|=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
		else $error("unmapped read not refused");
	read_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_rvalid && s_axi_rready) |=> s_axi_arready && !s_axi_rvalid)
		else $error("read channel not reopened");
	ar_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid |-> !s_axi_arready)
		else $error("second read taken while answer pending");

	// Write answers, with a single write in flight
	write_okay_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(do_write && wr_idx != IDX_NONE) |=> s_axi_bresp == RESP_OKAY)
		else $error("mapped write refused");
	write_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(do_write && wr_idx == IDX_NONE) |=> s_axi_bresp == RESP_SLVERR)
		else $error("unmapped write not refused");
	aw_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	ready_back_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_bvalid && s_axi_bready) |=> s_axi_awready && s_axi_wready && !s_axi_bvalid)
		else $error("write channels not reopened");

	// A control byte moves only on a mapped write with lane 0 enabled
	ctrl_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!(do_write && wr_strb0 && wr_idx != IDX_NONE)
		|=> $stable(ctrl[0]) && $stable(ctrl[1]) && $stable(ctrl[2])
			&& $stable(ctrl[3]) && $stable(ctrl[4]))
		else $error("control byte changed without a write");

endmodule : pptc_bank

`default_nettype wire

// File: pptc_bank_tb.sv
// Self-checking bench for the port priority and tag control bank
`timescale 1ns/1ps
`default_nettype none

module pptc_bank_tb;
	import pptc_pkg::*;

	// ----------------------------------------------------------------
	// Signals and counters
	// ----------------------------------------------------------------
	localparam int LIMIT = 20000;
	logic aclk, aresetn;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [PORTS-1:0] ing_valid, ing_dscp_hit, ing_dscp_high, ing_dot1p_hit, ing_dot1p_high;
	logic [PORTS-1:0] eg_valid, eg_rx_tagged, eg_prio_high;
	logic [PORTS-1:0][PIDX_W-1:0] eg_src_port, eg_vid_port;
	logic [PORTS-1:0] ing_storm_en, ing_prio_valid, ing_prio_high;
	logic [PORTS-1:0] eg_out_valid, eg_add_tag, eg_strip_tag, eg_queue_high;
	int num_errors = 0;
	int n_checks = 0;
	int cyc = 0;

	pptc_bank u_pptc_bank (
		.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.ing_valid, .ing_dscp_hit, .ing_dscp_high, .ing_dot1p_hit, .ing_dot1p_high,
		.eg_valid, .eg_rx_tagged, .eg_src_port, .eg_prio_high,
		.ing_storm_en, .ing_prio_valid, .ing_prio_high,
		.eg_out_valid, .eg_add_tag, .eg_strip_tag, .eg_vid_port, .eg_queue_high
	);

	// 50 MHz clock
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	// Hang guard, well above the roughly 10k cycles the run needs
	always @(posedge aclk) begin
		cyc++;
		if (cyc == LIMIT) begin
			num_errors++;
			end_of_test();
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	function automatic logic [7:0] reg_addr(input int p);
		return 8'((p + 1) * 16);
	endfunction : reg_addr

	// Address and data offered together; bready held until the answer
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st,
			input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) begin
				chk("bresp", 32'(er), 32'(s_axi_bresp));
				s_axi_bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) begin
				chk("rdata", ed, s_axi_rdata);
				chk("rresp", 32'(er), 32'(s_axi_rresp));
				s_axi_rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : axi_read

	// One packet on port p each way; other ports see hits but no valid
	task automatic pkt(input int p, input logic [7:0] c, input logic [3:0] i);
		logic u, h;
		logic [2:0] s;
		s = 3'(i % 5);
		u = (c[6] & i[0]) | (c[5] & i[2]);
		h = u ? ((c[6] & i[0] & i[1]) | (c[5] & i[2] & i[3])) : c[4];
		@(posedge aclk);
		ing_valid <= 5'(1 << p);
		ing_dscp_hit <= {5{i[0]}};
		ing_dscp_high <= {5{i[1]}};
		ing_dot1p_hit <= {5{i[2]}};
		ing_dot1p_high <= {5{i[3]}};
		eg_valid <= 5'(1 << p);
		eg_rx_tagged <= {5{i[0]}};
		eg_prio_high <= {5{i[1]}};
		eg_src_port <= 15'(s) << (3 * p);
		@(posedge aclk);
		ing_valid <= '0;
		eg_valid <= '0;
		#1;
		chk("prio_valid", 32'(1 << p), 32'(ing_prio_valid));
		chk("prio_high", 32'(h) << p, 32'(ing_prio_high));
		chk("out_valid", 32'(1 << p), 32'(eg_out_valid));
		chk("add_tag", 32'(c[2] & ~i[0]) << p, 32'(eg_add_tag));
		chk("strip_tag", 32'(c[1] & i[0]) << p, 32'(eg_strip_tag));
		chk("queue_high", 32'(c[0] & i[1]) << p, 32'(eg_queue_high));
		chk("vid_port", 32'(s) << (3 * p), 32'(eg_vid_port));
	endtask : pkt

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{ing_valid, ing_dscp_hit, ing_dscp_high, ing_dot1p_hit, ing_dot1p_high} = '0;
		{eg_valid, eg_rx_tagged, eg_prio_high, eg_src_port} = '0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		for (int p = 0; p < PORTS; p++) begin
			axi_read(reg_addr(p), 32'h0, RESP_OKAY);
		end
		// Upper bytes carry junk that must never land in a register
		for (int p = 0; p < PORTS; p++) begin
			axi_write(reg_addr(p), 32'hA5A5A500 | 32'(8'h2B + p * 8'h31), 4'hF, RESP_OKAY);
		end
		for (int p = 0; p < PORTS; p++) begin
			axi_read(reg_addr(p), 32'(8'(8'h2B + p * 8'h31)), RESP_OKAY);
		end
		axi_write(8'h10, 32'h0, 4'h0, RESP_OKAY);
		axi_write(8'h14, 32'hFF, 4'hF, RESP_SLVERR);
		axi_read(8'h10, 32'h2B, RESP_OKAY);
		axi_read(8'h14, 32'h0, RESP_SLVERR);
		axi_read(8'h60, 32'h0, RESP_SLVERR);
		// Every control byte, spread over the ports in turn
		for (int k = 0; k < 256; k++) begin
			axi_write(reg_addr(k % 5), 32'(k), 4'hF, RESP_OKAY);
			axi_read(reg_addr(k % 5), 32'(k), RESP_OKAY);
			for (int i = 0; i < 16; i++) begin
				pkt(k % 5, 8'(k), 4'(i));
			end
			chk("storm_en", 32'(k >> 7), 32'(ing_storm_en[k % 5]));
		end
		// Reset in mid-run must clear every byte written above
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		for (int p = 0; p < PORTS; p++) begin
			axi_read(reg_addr(p), 32'h0, RESP_OKAY);
		end
		@(posedge aclk);
		#1;
		chk("idle_ing", 32'h0, 32'(ing_prio_valid | ing_prio_high));
		chk("idle_eg", 32'h0, 32'(eg_out_valid | eg_add_tag | eg_strip_tag | eg_queue_high));
		chk("storm_rst", 32'h0, 32'(ing_storm_en));
		end_of_test();
	end

endmodule : pptc_bank_tb

`default_nettype wire

// File: pptc_pkg.sv
// Constants shared by the port priority and tag control bank
package pptc_pkg;

	// ----------------------------------------------------------------
	// Bus and port geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int PORTS = 5;
	localparam int PIDX_W = 3;

	// ----------------------------------------------------------------
	// Register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] PORT1_CTRL_OFS = 8'h10;
	localparam logic [7:0] PORT2_CTRL_OFS = 8'h20;
	localparam logic [7:0] PORT3_CTRL_OFS = 8'h30;
	localparam logic [7:0] PORT4_CTRL_OFS = 8'h40;
	localparam logic [7:0] PORT5_CTRL_OFS = 8'h50;
	localparam logic [2:0] IDX_NONE = 3'h7;

	// ----------------------------------------------------------------
	// Control byte fields and reset value
	// ----------------------------------------------------------------
	localparam int BIT_STORM = 7;
	localparam int BIT_DSCP = 6;
	localparam int BIT_DOT1P = 5;
	localparam int BIT_PORT_PRIO = 4;
	localparam int BIT_RSVD = 3;
	localparam int BIT_TAG_ADD = 2;
	localparam int BIT_TAG_STRIP = 1;
	localparam int BIT_SPLIT_Q = 0;
	localparam logic [7:0] CTRL_RST = 8'h00;

	// ----------------------------------------------------------------
	// AXI responses
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pptc_pkg

// File: pptc_port_if.sv
// Interface joining the register bank to one port's decision logic
`timescale 1ns/1ps
`default_nettype none

interface pptc_port_if;
	import pptc_pkg::*;

	logic [7:0] ctrl;
	logic ing_valid;
	logic dscp_hit;
	logic dscp_high;
	logic dot1p_hit;
	logic dot1p_high;
	logic eg_valid;
	logic eg_rx_tagged;
	logic [PIDX_W-1:0] eg_src_port;
	logic eg_prio_high;
	logic storm_en;
	logic ing_prio_valid;
	logic ing_prio_high;
	logic eg_out_valid;
	logic add_tag;
	logic strip_tag;
	logic [PIDX_W-1:0] vid_port;
	logic queue_high;

	modport cfg (
		output ctrl, ing_valid, dscp_hit, dscp_high, dot1p_hit, dot1p_high,
		output eg_valid, eg_rx_tagged, eg_src_port, eg_prio_high,
		input storm_en, ing_prio_valid, ing_prio_high, eg_out_valid,
		input add_tag, strip_tag, vid_port, queue_high
	);

	modport core (
		input ctrl, ing_valid, dscp_hit, dscp_high, dot1p_hit, dot1p_high,
		input eg_valid, eg_rx_tagged, eg_src_port, eg_prio_high,
		output storm_en, ing_prio_valid, ing_prio_high, eg_out_valid,
		output add_tag, strip_tag, vid_port, queue_high
	);

endinterface : pptc_port_if

`default_nettype wire

// File: pptc_port_logic.sv
// Per-port ingress classification and egress tag and queue decisions
`timescale 1ns/1ps
`default_nettype none

module pptc_port_logic (
	input wire logic aclk,
	input wire logic aresetn,
	pptc_port_if.core pif
);
	import pptc_pkg::*;

	logic dscp_used;
	logic dot1p_used;
	logic next_prio;

	// ----------------------------------------------------------------
	// Ingress classification
	// ----------------------------------------------------------------

	// A method only counts when enabled and it found a priority
	assign dscp_used = pif.ctrl[BIT_DSCP] && pif.dscp_hit;
	assign dot1p_used = pif.ctrl[BIT_DOT1P] && pif.dot1p_hit;

	// OR of both methods beats the port default
	always_comb begin
		if (dscp_used || dot1p_used) begin
			next_prio = (dscp_used && pif.dscp_high) || (dot1p_used && pif.dot1p_high);
		end else begin
			next_prio = pif.ctrl[BIT_PORT_PRIO];
		end
	end

	// Registered ingress results
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pif.storm_en <= 1'b0;
			pif.ing_prio_valid <= 1'b0;
			pif.ing_prio_high <= 1'b0;
		end else begin
			pif.storm_en <= pif.ctrl[BIT_STORM];
			pif.ing_prio_valid <= pif.ing_valid;
			pif.ing_prio_high <= pif.ing_valid && next_prio;
		end
	end

	// ----------------------------------------------------------------
	// Egress tag handling and queue choice
	// ----------------------------------------------------------------

	// Tag edits only look at the tag state seen on reception
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pif.eg_out_valid <= 1'b0;
			pif.add_tag <= 1'b0;
			pif.strip_tag <= 1'b0;
			pif.vid_port <= '0;
			pif.queue_high <= 1'b0;
		end else begin
			pif.eg_out_valid <= pif.eg_valid;
			pif.add_tag <= pif.eg_valid && pif.ctrl[BIT_TAG_ADD] && !pif.eg_rx_tagged;
			pif.strip_tag <= pif.eg_valid && pif.ctrl[BIT_TAG_STRIP] && pif.eg_rx_tagged;
			pif.vid_port <= pif.eg_src_port;
			pif.queue_high <= pif.eg_valid && pif.ctrl[BIT_SPLIT_Q] && pif.eg_prio_high;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	storm_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 pif.storm_en == $past(pif.ctrl[BIT_STORM]))
		else $error("storm enable does not follow control bit");
	prio_port_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(pif.ing_valid && !dscp_used && !dot1p_used)
		|=> pif.ing_prio_high == $past(pif.ctrl[BIT_PORT_PRIO]))
		else $error("port default priority not applied");
	prio_or_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(pif.ing_valid && ((dscp_used && pif.dscp_high) || (dot1p_used && pif.dot1p_high)))
		|=> pif.ing_prio_high && pif.ing_prio_valid)
		else $error("classified high priority lost");
	prio_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(pif.ing_valid && (dscp_used || dot1p_used) && !next_prio) |=> !pif.ing_prio_high)
		else $error("classified low priority overridden");
	tag_add_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(pif.eg_valid && pif.ctrl[BIT_TAG_ADD] && !pif.eg_rx_tagged) |=> pif.add_tag)
		else $error("untagged packet not given a tag");
	no_double_a: assert property (@(posedge aclk) disable iff (!aresetn)
		pif.eg_rx_tagged |=> !pif.add_tag)
		else $error("tag added to tagged packet");
	vid_src_a: assert property (@(posedge aclk) disable iff (!aresetn)
		pif.eg_valid |=> pif.vid_port == $past(pif.eg_src_port))
		else $error("inserted VID not from ingress port");
	strip_tag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		pif.eg_valid |=> pif.strip_tag == $past(pif.ctrl[BIT_TAG_STRIP] && pif.eg_rx_tagged))
		else $error("tag removal wrong");
	queue_split_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(pif.eg_valid && pif.ctrl[BIT_SPLIT_Q] && pif.eg_prio_high) |=> pif.queue_high)
		else $error("high priority packet not in high queue");
	queue_single_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!pif.ctrl[BIT_SPLIT_Q] |=> !pif.queue_high)
		else $error("high queue used in single queue mode");

endmodule : pptc_port_logic

`default_nettype wire
